// *** rtl/cbd_channel_b.sv ***
// cbd_channel_b: channel b divider, phase, polarity and driver control
// assumes halfTick pulses once per half period of the prescaler clock,
// and syncIn is asynchronous to clock
//
// Functional notes
// - output divides the input clock by the 10-bit value plus one.
// - divider value is low byte bits 7:0 and next byte bits 1:0.
// - 6-bit phase sets start delay after sync in half input periods.
// - phase zero gives no delay, one delays by half a period.
// - drive field 00/01/10 sets current, 11 powers down and tristates.
// - lowest settings bit inverts output polarity when set.
// - reset gives lowest drive, normal polarity, zero low divider and phase.
`default_nettype none

module cbd_channel_b
  import cbd_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire cbd_bus_req_t busReq,
  output logic [7:0]        rdata,
  input  wire logic         halfTick,
  input  wire logic         syncIn,
  output cbd_pair_t         channel_b_output,
  output logic [1:0]        channel_b_drive_select
);

  // ==========================================================
  // state registers
  cbd_state_t s_reg;
  cbd_state_t s_next;
  logic [9:0]  divValue;
  logic [10:0] halfTop;
  logic        syncRise;
  logic [10:0] cntNext;

  assign divValue = {s_reg.divHigh_reg, s_reg.divLow_reg};
  assign halfTop  = {divValue, 1'b1};
  assign syncRise = s_reg.syncSync & ~s_reg.syncPrev;
  // wrap also when a smaller ratio was written while the count stood above the new top
  assign cntNext  = (s_reg.halfCnt >= halfTop) ? 11'h000 : s_reg.halfCnt + 11'h001;

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.rdata = CBD_READ_NONE;
    // register writes
    if (busReq.wr) begin
      unique case (busReq.addr)
        CBD_ADDR_CONFIG:   s_next.config_reg  = busReq.wdata[2:0];
        CBD_ADDR_DIV_LOW:  s_next.divLow_reg  = busReq.wdata;
        CBD_ADDR_DIV_HIGH: s_next.divHigh_reg = busReq.wdata[1:0];
        CBD_ADDR_PHASE:    s_next.phase_reg   = busReq.wdata[5:0];
        default:           s_next.rdata       = CBD_READ_NONE;
      endcase
    end
    // register reads, reserved bits as zero
    if (busReq.rd) begin
      unique case (busReq.addr)
        CBD_ADDR_CONFIG:   s_next.rdata = {5'h00, s_reg.config_reg};
        CBD_ADDR_DIV_LOW:  s_next.rdata = s_reg.divLow_reg;
        CBD_ADDR_DIV_HIGH: s_next.rdata = {6'h00, s_reg.divHigh_reg};
        CBD_ADDR_PHASE:    s_next.rdata = {2'h0, s_reg.phase_reg};
        default:           s_next.rdata = CBD_READ_NONE;
      endcase
    end
    // sync synchroniser and edge history
    s_next.syncMeta = syncIn;
    s_next.syncSync = s_reg.syncMeta;
    s_next.syncPrev = s_reg.syncSync;
    // divider and phase delay
    if (syncRise) begin
      s_next.halfCnt  = 11'h000;
      s_next.delayCnt = s_reg.phase_reg;
      s_next.holding  = (s_reg.phase_reg != 6'h00);
      s_next.divClk   = (s_reg.phase_reg == 6'h00);
    end else if (halfTick && s_reg.holding) begin
      s_next.delayCnt = s_reg.delayCnt - 6'h01;
      if (s_reg.delayCnt == 6'h01) begin
        s_next.holding = 1'b0;
        s_next.halfCnt = 11'h000;
        s_next.divClk  = 1'b1;
      end
    end else if (halfTick) begin
      s_next.halfCnt = cntNext;
      s_next.divClk  = (cntNext <= {1'b0, divValue});
    end
    // output pair: polarity and driver mode
    s_next.drive = s_next.config_reg[CBD_DRIVE_LSB +: 2];
    if (s_next.drive == CBD_DRIVE_OFF) begin
      s_next.pair = '{pos: 1'b0, neg: 1'b0, oeN: 1'b1};
    end else begin
      s_next.pair.pos = s_next.divClk ^ s_next.config_reg[CBD_POL_BIT];
      s_next.pair.neg = ~s_next.pair.pos;
      s_next.pair.oeN = 1'b0;
    end
  end

  // ==========================================================
  // register the state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg             <= '0;
      s_reg.config_reg  <= CBD_CONFIG_RESET;
      s_reg.divLow_reg  <= CBD_DIV_LOW_RESET;
      s_reg.divHigh_reg <= CBD_DIV_HIGH_RESET;
      s_reg.phase_reg   <= CBD_PHASE_RESET;
      s_reg.pair        <= '{pos: 1'b0, neg: 1'b1, oeN: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign rdata                  = s_reg.rdata;
  assign channel_b_output       = s_reg.pair;
  assign channel_b_drive_select = s_reg.drive;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_div_bound;
    (halfTick && !syncRise && !s_reg.holding && !busReq.wr) |=> (s_reg.halfCnt <= halfTop);
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("half count past top");

  property p_div_wrap;
    (halfTick && !syncRise && !s_reg.holding && s_reg.halfCnt == halfTop && !busReq.wr)
      |=> (s_reg.halfCnt == 11'h000 && s_reg.divClk);
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

  property p_read_high;
    (busReq.rd && busReq.addr == CBD_ADDR_DIV_HIGH)
      |=> (rdata == {6'h00, $past(s_reg.divHigh_reg)});
  endproperty
  a_read_high: assert property (p_read_high) else $error("high divider read wrong");

  property p_phase_step;
    (halfTick && s_reg.holding && !syncRise)
      |=> (s_reg.delayCnt == $past(s_reg.delayCnt) - 6'h01);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase delay not counting");

  property p_phase_zero;
    (syncRise && s_reg.phase_reg == 6'h00) |=> (!s_reg.holding && s_reg.divClk);
  endproperty
  a_phase_zero: assert property (p_phase_zero) else $error("zero phase delayed start");

  property p_power_down;
    (s_reg.drive == CBD_DRIVE_OFF) |-> (s_reg.pair.oeN && !s_reg.pair.pos && !s_reg.pair.neg);
  endproperty
  a_power_down: assert property (p_power_down) else $error("pair driven in power down");

  property p_polarity;
    (s_reg.drive != CBD_DRIVE_OFF)
      |-> (s_reg.pair.pos == (s_reg.divClk ^ s_reg.config_reg[CBD_POL_BIT])) && (s_reg.pair.neg != s_reg.pair.pos);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity mismatch");

  property p_reset_vals;
    $rose(rst_n) |-> (s_reg.config_reg == CBD_CONFIG_RESET && s_reg.divLow_reg == CBD_DIV_LOW_RESET
      && s_reg.phase_reg == CBD_PHASE_RESET);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_sync_restart;
    syncRise |=> (s_reg.halfCnt == 11'h000 && s_reg.delayCnt == $past(s_reg.phase_reg));
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart");

endmodule

`default_nettype wire

// *** rtl/cbd_pkg.sv ***
// cbd_pkg: shared constants and types for the channel b output divider
// assumes a byte-wide register port and one 10 MHz system clock
`default_nettype none

package cbd_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] CBD_ADDR_CONFIG   = 16'h043b;
  localparam logic [15:0] CBD_ADDR_DIV_LOW  = 16'h043c;
  localparam logic [15:0] CBD_ADDR_DIV_HIGH = 16'h043d;
  localparam logic [15:0] CBD_ADDR_PHASE    = 16'h043e;

  // ==========================================================
  // field layout and reset values
  localparam int          CBD_POL_BIT       = 0;
  localparam int          CBD_DRIVE_LSB     = 1;
  localparam logic [2:0]  CBD_CONFIG_RESET  = 3'h0;
  localparam logic [7:0]  CBD_DIV_LOW_RESET = 8'h00;
  localparam logic [1:0]  CBD_DIV_HIGH_RESET = 2'h0;
  localparam logic [5:0]  CBD_PHASE_RESET   = 6'h00;
  localparam logic [7:0]  CBD_READ_NONE     = 8'h00;

  // ==========================================================
  // driver modes
  typedef enum logic [1:0] {
    CBD_DRIVE_LOW  = 2'h0,
    CBD_DRIVE_MID  = 2'h1,
    CBD_DRIVE_HIGH = 2'h2,
    CBD_DRIVE_OFF  = 2'h3
  } cbd_drive_t;

  // ==========================================================
  // register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cbd_bus_req_t;

  // differential output pair
  typedef struct packed {
    logic pos;
    logic neg;
    logic oeN;
  } cbd_pair_t;

  // whole state of the block
  typedef struct packed {
    logic [2:0]  config_reg;
    logic [7:0]  divLow_reg;
    logic [1:0]  divHigh_reg;
    logic [5:0]  phase_reg;
    logic [7:0]  rdata;
    logic        syncMeta;
    logic        syncSync;
    logic        syncPrev;
    logic [10:0] halfCnt;
    logic [5:0]  delayCnt;
    logic        holding;
    logic        divClk;
    cbd_pair_t   pair;
    logic [1:0]  drive;
  } cbd_state_t;

endpackage

`default_nettype wire

// *** test/cbd_clock_rx.sv ***
// cbd_clock_rx: downstream receiver model, measures the high time of the pair
// assumes the pair is sampled on the system clock rising edge
`default_nettype none

module cbd_clock_rx
  import cbd_pkg::*;
(
  input  wire logic       clock,
  input  wire cbd_pair_t  pair,
  output var logic [15:0] highWidth
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] runLen = 16'h0000;

  // ==========================================================
  // count high samples, latch run length on the fall
  initial highWidth = 16'h0000;
  always @(posedge clock) begin
    if (pair.pos) begin
      runLen <= runLen + 16'h0001;
    end else begin
      if (runLen != 16'h0000) highWidth <= runLen;
      runLen <= 16'h0000;
    end
  end
endmodule

`default_nettype wire

// *** test/cbd_channel_b_tb_top.sv ***
// cbd_channel_b_tb_top: self-checking bench for the channel b divider
// assumes 10 MHz clock, synchronous active-low reset, halfTick from the bench
`default_nettype none

module cbd_channel_b_tb_top
  import cbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  cbd_bus_req_t busReq = '0;
  logic         halfTick = 1'b0;
  logic         syncIn = 1'b0;
  logic [7:0]   rdata;
  cbd_pair_t    chOut;
  logic [1:0]   driveSel;
  logic [15:0]  highWidth;
  int           n_errors = 0;
  int           check_count = 0;
  int           cnt;
  int           base;

  cbd_channel_b uut (.clock(clock), .rst_n(rst_n), .busReq(busReq), .rdata(rdata), .halfTick(halfTick),
    .syncIn(syncIn), .channel_b_output(chOut), .channel_b_drive_select(driveSel));
  cbd_clock_rx rx (.clock(clock), .pair(chOut), .highWidth(highWidth));

  // ==========================================================
  // clock, bus and compare helpers
  always #50 clock = ~clock;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock) busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock) busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock) busReq.rd <= 1'b0;
    @(negedge clock) chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic sync();
    @(posedge clock) syncIn <= 1'b1;
    repeat (4) @(posedge clock);
    syncIn <= 1'b0;
    repeat (5) @(posedge clock);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_div(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] w);
    wr(CBD_ADDR_DIV_LOW, lo);
    wr(CBD_ADDR_DIV_HIGH, hi);
    wr(CBD_ADDR_PHASE, 8'h00);
    sync();
    halfTick <= 1'b1;
    repeat (3 * w + 8) @(posedge clock);
    halfTick <= 1'b0;
    chk("highWidth", w, highWidth);
    $display("divide test %0d done", w);
  endtask
  task automatic t_phase(input logic [7:0] p);
    wr(CBD_ADDR_PHASE, p);
    sync();
    @(negedge clock) chk("posAfterSync", {15'h0, p == 8'h00}, {15'h0, chOut.pos});
    @(posedge clock) halfTick <= 1'b1;
    cnt = 0;
    @(negedge clock);
    while (!chOut.pos && cnt < 200) begin
      @(negedge clock);
      cnt++;
    end
    @(posedge clock) halfTick <= 1'b0;
    $display("phase test %0d done", p);
  endtask

  // ==========================================================
  // main sequence and watchdog
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock) chk("pairReset", 16'h0002, {13'h0, chOut});
    chk("driveReset", 16'h0000, {14'h0, driveSel});
    rd(CBD_ADDR_CONFIG, 8'h00);
    rd(CBD_ADDR_DIV_LOW, 8'h00);
    rd(CBD_ADDR_PHASE, 8'h00);
    wr(16'h043f, 8'h55);
    rd(16'h043f, 8'h00);
    wr(CBD_ADDR_DIV_HIGH, 8'hff);
    rd(CBD_ADDR_DIV_HIGH, 8'h03);
    wr(CBD_ADDR_PHASE, 8'hff);
    rd(CBD_ADDR_PHASE, 8'h3f);
    $display("register test done");
    t_div(8'h00, 8'h00, 16'd1);
    t_div(8'h02, 8'h00, 16'd3);
    t_div(8'h00, 8'h01, 16'd257);
    t_div(8'hff, 8'h03, 16'd1024);
    wr(CBD_ADDR_DIV_LOW, 8'h02);
    wr(CBD_ADDR_DIV_HIGH, 8'h00);
    t_phase(8'h00);
    chk("phaseZero", 16'h0000, cnt[15:0]);
    t_phase(8'h01);
    base = cnt;
    t_phase(8'h05);
    chk("phaseFive", base[15:0] + 16'h0004, cnt[15:0]);
    t_phase(8'h3f);
    chk("phaseMax", base[15:0] + 16'h003e, cnt[15:0]);
    wr(CBD_ADDR_PHASE, 8'h00);
    for (int d = 0; d < 4; d++) begin
      wr(CBD_ADDR_CONFIG, 8'(d * 2));
      sync();
      @(negedge clock) chk("driveSel", 16'(d), {14'h0, driveSel});
      chk("pairMode", (d == 3) ? 16'h0001 : 16'h0004, {13'h0, chOut});
    end
    wr(CBD_ADDR_CONFIG, 8'h01);
    sync();
    @(negedge clock) chk("pairInverted", 16'h0002, {13'h0, chOut});
    $display("output test done");
    summarize();
  end
endmodule

`default_nettype wire
